// ---- core/tccu_regs.vh ----
// tccu_regs.vh: register offsets, field positions, reset values and timing counts
// assumes: included by the timer compare/capture design files, Wishbone byte addresses
`ifndef TCCU_REGS_VH
`define TCCU_REGS_VH

// ==========================================================================
// register byte offsets
`define TCCU_OFS_CTRL      8'h00
`define TCCU_OFS_PRESCALE  8'h04
`define TCCU_OFS_CAPCMP    8'h08
`define TCCU_OFS_EDGE      8'h0C
`define TCCU_OFS_CMP_A     8'h10
`define TCCU_OFS_CMP_B     8'h14
`define TCCU_OFS_CAP_C     8'h18
`define TCCU_OFS_COUNT     8'h1C
`define TCCU_OFS_STATUS    8'h20

// ==========================================================================
// control register fields
`define TCCU_CTRL_WIDTH    0
`define TCCU_CTRL_NEIGHBOR 2
`define TCCU_CTRL_RUN      3
// capcmp_control fields
`define TCCU_CC_BCAP       0
`define TCCU_CC_CLR_A      2
`define TCCU_CC_CLR_B      3
// status fields
`define TCCU_ST_OVF        0
`define TCCU_ST_TRIG       1

// ==========================================================================
// reset values
`define TCCU_RST_CTRL      8'h00
`define TCCU_RST_PRESCALE  4'h0
`define TCCU_RST_CAPCMP    8'h00
`define TCCU_RST_EDGE      2'h0
`define TCCU_RST_WORD      16'h0000

// ==========================================================================
// edge select encodings
`define TCCU_EDGE_FALL     2'h0
`define TCCU_EDGE_RISE     2'h1
`define TCCU_EDGE_BOTH     2'h3

// ==========================================================================
// timing: prescale divisor is 4 shl select, select 0..8 gives 4..1024
`define TCCU_DIV_MIN       11'h004
`define TCCU_SEL_MAX       4'h8
`define TCCU_SEL_EXT       4'hF
`define TCCU_MIN_LEVEL     3

`endif

// ---- core/tccu_trigger.v ----
// tccu_trigger.v: synchroniser and valid-edge detector for the trigger pin
// assumes: pin is asynchronous to clk; sampling clock is clk itself
`timescale 1ns/1ps
`default_nettype none
`include "tccu_regs.vh"

module tccu_trigger (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // pin and configuration
    input  wire       trigger_input,
    input  wire [1:0] edge_select,
    // result
    output reg        trig_edge
);

    reg       sync_a;
    reg       sync_b;
    reg [1:0] run;
    reg       level;
    wire      stable;
    wire      rise;
    wire      fall;

    // ======================================================================
    // two-stage synchroniser, then a level filter needing three equal samples
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            run    <= 2'h0;
            level  <= 1'b0;
        end else begin
            sync_a <= trigger_input;
            sync_b <= sync_a;
            if (sync_b == level) begin
                run <= 2'h0;
            end else if (run == 2'h2) begin
                run   <= 2'h0;
                level <= sync_b;
            end else begin
                run <= run + 2'h1;
            end
        end
    end

    // a level shorter than three samples is never accepted [RULE7]
    assign stable = (sync_b != level) && (run == 2'h2);
    assign rise   = stable && sync_b;
    assign fall   = stable && !sync_b;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_edge <= 1'b0;
        end else begin
            case (edge_select)
                `TCCU_EDGE_RISE: trig_edge <= rise; // [RULE5]
                `TCCU_EDGE_BOTH: trig_edge <= rise | fall; // [RULE5]
                default:         trig_edge <= fall;
            endcase
        end
    end

endmodule // tccu_trigger

`default_nettype wire

// ---- core/tccu_top.v ----
// tccu_top.v: 8/16-bit up counter with two compare paths and capture path
// assumes: classic Wishbone slave on clk, one-cycle ack; irq pulses go to an
// external interrupt controller that does its own masking
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tccu_regs.vh"

// Notes on behaviour
// RULE1: count matching compare_a or compare_capture_b (compare mode) raises its irq.
// RULE2: clear-on-match turns the counter into an interval timer.
// RULE3: valid trigger edge latches count into capture_c and, if capture, into b.
// RULE4: captured values stay until the next capture trigger.
// RULE5: edge_select_reg picks rising, falling or both trigger edges.
// RULE6: b in capture with clear_on_b clears count after the latch.
// RULE7: trigger levels shorter than three samples may be missed.
// RULE8: count clock is 4 to 1024 main clocks, power-of-two steps.
// RULE9: clear-on-match period is compare value plus one count clocks.
// RULE10: both compares work at once on a free-running count.
// RULE11: software computes pulse width from successive captures.
// RULE12: software stops counter before changing prescale or mode bits.
// RULE13: a match at the stop instant still raises its irq.
// RULE14: first count may wait up to one count clock after start.
// RULE15: writing a compare register masks its match that cycle.
// RULE16: software writes compares only away from old and new values.
// RULE17: matches are detected only on a count increment.
// RULE18: event mode reads zero after no edge or one edge.
// RULE19: capcmp_control holds clear_on_a, clear_on_b and b_capture_select.
// RULE20: a clear source holds count, zeroing it on the next count clock.
// RULE21: clearing count_run zeroes count and stops capture and matches.
// RULE22: width_select chooses 16-bit counter and registers.
// RULE23: each match or capture gives a one-cycle irq pulse.
module tccu_top (
    // clock and reset
    input  wire        clk,
    input  wire        resetn,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // external pin
    input  wire        trigger_input,
    // interrupt requests
    output reg         match_a_irq,
    output reg         match_b_irq,
    output reg         capture_irq
);

    reg        rst_s1;
    reg        rst_n;
    reg  [7:0] timer_control;
    reg  [3:0] prescale_select;
    reg  [7:0] capcmp_control;
    reg  [1:0] edge_select_reg;
    reg [15:0] compare_a;
    reg [15:0] compare_capture_b;
    reg [15:0] capture_c;
    reg [15:0] count_value;
    reg [10:0] pre_cnt;
    reg        started;
    reg        clr_pend;
    reg        ovf_flag;
    reg        trig_flag;
    reg        next_ack;
    reg [31:0] next_dat;

    wire        trig_edge;
    wire        wide_mode;
    wire        count_run;
    wire        b_capture_select;
    wire        clear_on_a;
    wire        clear_on_b;
    wire        wr;
    wire        rd;
    wire        wr_ctrl;
    wire        wr_a;
    wire        wr_b;
    wire [10:0] divisor;
    wire        tick;
    wire        inc;
    wire [15:0] count_inc;
    wire [15:0] top_val;
    wire [15:0] mask;
    wire        hit_a;
    wire        hit_b;
    wire        capture;
    wire        run_going;
    wire        ovf_clr;

    // ======================================================================
    // reset release through two flops
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // ======================================================================
    // field decode
    assign wide_mode        = timer_control[`TCCU_CTRL_WIDTH];
    assign count_run        = timer_control[`TCCU_CTRL_RUN];
    assign b_capture_select = capcmp_control[`TCCU_CC_BCAP];  // [RULE19]
    assign clear_on_a       = capcmp_control[`TCCU_CC_CLR_A]; // [RULE19]
    assign clear_on_b       = capcmp_control[`TCCU_CC_CLR_B]; // [RULE19]
    assign mask             = wide_mode ? 16'hFFFF : 16'h00FF; // [RULE22]

    assign wr      = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd      = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign wr_ctrl = wr && (wb_adr_i == `TCCU_OFS_CTRL) && wb_sel_i[0];
    assign wr_a    = wr && (wb_adr_i == `TCCU_OFS_CMP_A);
    assign wr_b    = wr && (wb_adr_i == `TCCU_OFS_CMP_B) && !b_capture_select;

    // ======================================================================
    // trigger pin edge detection
    tccu_trigger u_trigger (
        .clk           (clk),
        .rst_n         (rst_n),
        .trigger_input (trigger_input),
        .edge_select   (edge_select_reg),
        .trig_edge     (trig_edge)
    );

    // ======================================================================
    // prescaler: a selection of 15 counts trigger edges (event mode)
    assign divisor = `TCCU_DIV_MIN << ((prescale_select > `TCCU_SEL_MAX) ?
                     `TCCU_SEL_MAX : prescale_select); // [RULE8]
    assign tick    = (prescale_select == `TCCU_SEL_EXT) ? trig_edge :
                     (pre_cnt == divisor - 11'h001);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= 11'h000;
        end else if (!count_run || tick || prescale_select == `TCCU_SEL_EXT) begin
            // free-running phase is reset at stop, so start latency is up to one tick
            pre_cnt <= 11'h000; // [RULE14]
        end else begin
            pre_cnt <= pre_cnt + 11'h001;
        end
    end

    // ======================================================================
    // counter
    assign run_going = count_run && started;
    assign inc       = run_going && tick && !clr_pend;
    assign count_inc = (count_value + 16'h0001) & mask;
    // a match is only looked for on the increment, and not while its register
    // is being written
    assign hit_a     = inc && (count_inc == (compare_a & mask)) && !wr_a;
    assign hit_b     = inc && !b_capture_select &&
                       (count_inc == (compare_capture_b & mask)) && !wr_b;
    assign capture   = count_run && trig_edge; // [RULE21]
    assign top_val   = mask;
    assign ovf_clr   = wr && (wb_adr_i == `TCCU_OFS_STATUS) && wb_dat_i[`TCCU_ST_OVF];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_value <= `TCCU_RST_WORD;
            started     <= 1'b0;
            clr_pend    <= 1'b0;
            ovf_flag    <= 1'b0;
        end else if (!count_run) begin
            count_value <= `TCCU_RST_WORD; // [RULE21]
            started     <= 1'b0;
            clr_pend    <= 1'b0;
            if (ovf_clr) begin
                ovf_flag <= 1'b0;
            end
        end else begin
            // the set further down is assigned later, so it wins over a clear
            if (ovf_clr) begin
                ovf_flag <= 1'b0;
            end
            if (!started) begin
                // first count clock after start zeroes the count [RULE14]
                if (tick) begin
                    started     <= 1'b1;
                    count_value <= `TCCU_RST_WORD;
                end
            end else if (tick && clr_pend) begin
                count_value <= `TCCU_RST_WORD; // [RULE20]
                clr_pend    <= 1'b0;
            end else if (inc) begin
                count_value <= count_inc; // [RULE10]
                if (count_value == top_val) begin
                    ovf_flag <= 1'b1;
                end
            end
            if ((hit_a && clear_on_a) || (hit_b && clear_on_b)) begin
                clr_pend <= 1'b1; // [RULE2] [RULE9]
            end
            if (capture && b_capture_select && clear_on_b && started) begin
                clr_pend <= 1'b1; // [RULE6]
            end
        end
    end

    // ======================================================================
    // capture register capture_c, interrupt pulses and sticky edge flag
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_c   <= `TCCU_RST_WORD;
            match_a_irq <= 1'b0;
            match_b_irq <= 1'b0;
            capture_irq <= 1'b0;
            trig_flag   <= 1'b0;
        end else begin
            if (capture) begin
                capture_c <= count_value & mask; // [RULE3] [RULE4]
            end
            // a stop write in the match cycle does not suppress the pulse
            match_a_irq <= hit_a; // [RULE1] [RULE13] [RULE15] [RULE17] [RULE23]
            match_b_irq <= hit_b || (capture && b_capture_select); // [RULE1] [RULE23]
            capture_irq <= capture; // [RULE23]
            // sticky edge flag tells one edge from none in event mode; set wins
            if (trig_edge) begin
                trig_flag <= 1'b1; // [RULE18]
            end else if (wr && wb_adr_i == `TCCU_OFS_STATUS && wb_dat_i[`TCCU_ST_TRIG]) begin
                trig_flag <= 1'b0;
            end
        end
    end

    // ======================================================================
    // software registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_control     <= `TCCU_RST_CTRL;
            prescale_select   <= `TCCU_RST_PRESCALE;
            capcmp_control    <= `TCCU_RST_CAPCMP;
            edge_select_reg   <= `TCCU_RST_EDGE;
            compare_a         <= `TCCU_RST_WORD;
            compare_capture_b <= `TCCU_RST_WORD;
        end else begin
            if (wr_ctrl) begin
                timer_control <= wb_dat_i[7:0] & 8'h0D;
            end
            if (wr && wb_adr_i == `TCCU_OFS_PRESCALE && wb_sel_i[0]) begin
                prescale_select <= wb_dat_i[3:0];
            end
            if (wr && wb_adr_i == `TCCU_OFS_CAPCMP && wb_sel_i[0]) begin
                capcmp_control <= wb_dat_i[7:0] & 8'h0D;
            end
            if (wr && wb_adr_i == `TCCU_OFS_EDGE && wb_sel_i[0]) begin
                edge_select_reg <= wb_dat_i[1:0];
            end
            if (wr_a && wb_sel_i[0]) begin
                compare_a[7:0] <= wb_dat_i[7:0];
            end
            if (wr_a && wb_sel_i[1]) begin
                compare_a[15:8] <= wb_dat_i[15:8];
            end
            if (capture && b_capture_select) begin
                compare_capture_b <= count_value & mask; // [RULE3] [RULE4]
            end else if (wr_b && wb_sel_i[0]) begin
                compare_capture_b[7:0] <= wb_dat_i[7:0];
            end
            if (!(capture && b_capture_select) && wr_b && wb_sel_i[1]) begin
                compare_capture_b[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // ======================================================================
    // wishbone read mux and ack; unmapped reads return zero
    always @* begin
        next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_dat = 32'h00000000;
        case (wb_adr_i)
            `TCCU_OFS_CTRL:     next_dat = {24'h000000, timer_control};
            `TCCU_OFS_PRESCALE: next_dat = {28'h0000000, prescale_select};
            `TCCU_OFS_CAPCMP:   next_dat = {24'h000000, capcmp_control};
            `TCCU_OFS_EDGE:     next_dat = {30'h00000000, edge_select_reg};
            `TCCU_OFS_CMP_A:    next_dat = {16'h0000, compare_a & mask};
            `TCCU_OFS_CMP_B:    next_dat = {16'h0000, compare_capture_b & mask};
            `TCCU_OFS_CAP_C:    next_dat = {16'h0000, capture_c};
            `TCCU_OFS_COUNT:    next_dat = {16'h0000, count_value};
            `TCCU_OFS_STATUS:   next_dat = {30'h00000000, trig_flag, ovf_flag};
            default:            next_dat = 32'h00000000;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= next_ack;
            if (rd) begin
                wb_dat_o <= next_dat;
            end
        end
    end

endmodule // tccu_top

`default_nettype wire

// ---- testbench/tccu_pulse_src.sv ----
// tccu_pulse_src.sv: external pulse source on the trigger pin
// assumes: driven from the bench by task calls, push-pull pin
`timescale 1ns/1ps
`default_nettype none
module tccu_pulse_src (
    // clock
    input  wire logic clk,
    // pin
    output logic      trigger_input
);
    initial trigger_input = 1'b0;
    // levels under three clocks are only asked for on purpose
    task automatic pulse(input int hi, input int lo);
        @(posedge clk);
        trigger_input <= 1'b1;
        repeat (hi) @(posedge clk);
        trigger_input <= 1'b0;
        repeat (lo) @(posedge clk);
    endtask
endmodule // tccu_pulse_src
`default_nettype wire

// ---- testbench/tccu_top_sva.sv ----
// tccu_top_sva.sv: port checks for the timer compare/capture unit
// assumes: bound to tccu_top, one clock, active-low reset
`timescale 1ns/1ps
`default_nettype none
module tccu_top_sva (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // pin and irqs
    input wire logic trigger_input,
    input wire logic match_a_irq,
    input wire logic match_b_irq,
    input wire logic capture_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // =====================================================
    // cycles since the pin last moved, saturating
    logic       pin_last;
    logic [3:0] since_chg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_last  <= 1'b0;
            since_chg <= 4'hF;
        end else begin
            pin_last <= trigger_input;
            if (trigger_input != pin_last)
                since_chg <= 4'h0;
            else if (since_chg != 4'hF)
                since_chg <= since_chg + 4'h1;
        end
    end
    // =====================================================
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
    property p_ma_pulse;
        match_a_irq |=> !match_a_irq;
    endproperty
    a_ma_pulse: assert property (p_ma_pulse) else $error("irq a long");
    property p_mb_pulse;
        match_b_irq |=> !match_b_irq;
    endproperty
    a_mb_pulse: assert property (p_mb_pulse) else $error("irq b long");
    property p_cap_pulse;
        capture_irq |=> !capture_irq;
    endproperty
    a_cap_pulse: assert property (p_cap_pulse) else $error("capture long");
    // a capture needs a settled pin edge a few clocks earlier
    property p_cap_cause;
        capture_irq |-> since_chg >= 4'h3 && since_chg <= 4'hC;
    endproperty
    a_cap_cause: assert property (p_cap_cause) else $error("stray capture");
    property p_rst_quiet;
        $rose(resetn) |-> !(match_a_irq || match_b_irq || capture_irq) [*2];
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("irq at reset");
endmodule // tccu_top_sva
bind tccu_top tccu_top_sva chk_u (
    .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .trigger_input(trigger_input), .match_a_irq(match_a_irq),
    .match_b_irq(match_b_irq), .capture_irq(capture_irq)
);
`default_nettype wire

// ---- testbench/tccu_top_test.sv ----
// tccu_top_test.sv: self-checking bench for the timer compare/capture unit
// assumes: prescale select 0, so one count tick every 4 clocks
`timescale 1ns/1ps
`default_nettype none
module tccu_top_test;
    typedef struct packed {logic we; logic [7:0] adr; logic [31:0] dat;} tccu_row_t;
    logic        clk, resetn, cyc, stb, we, ack;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q, v;
    wire logic   pin;
    logic        irq_a, irq_b, irq_c;
    int          error_cnt, compares, ncap, n;
    // reads carry the expected value in dat
    tccu_row_t rows [17] = '{
        {1'b0,8'h00,32'h0}, {1'b0,8'h08,32'h0}, {1'b0,8'h0C,32'h0}, {1'b0,8'h10,32'h0},
        {1'b0,8'h14,32'h0}, {1'b0,8'h1C,32'h0}, {1'b1,8'h10,32'h55}, {1'b0,8'h10,32'h55},
        {1'b1,8'h08,32'h0D}, {1'b0,8'h08,32'h0D}, {1'b1,8'h0C,32'h3}, {1'b0,8'h0C,32'h3},
        {1'b1,8'h18,32'h77}, {1'b0,8'h18,32'h0}, {1'b1,8'h40,32'hFF}, {1'b0,8'h40,32'h0},
        {1'b1,8'h08,32'h0}};
    // {edge mode, expected captures for one pulse}
    logic [3:0] modes [4] = '{4'b0001, 4'b0101, 4'b1110, 4'b1001};
    tccu_top dut_u (
        .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .trigger_input(pin), .match_a_irq(irq_a), .match_b_irq(irq_b), .capture_irq(irq_c));
    tccu_pulse_src src_u (.clk(clk), .trigger_input(pin));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (irq_c === 1'b1) ncap <= ncap + 1;
    // =====================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1) begin
            k++;
            @(posedge clk);
        end
        chk(32'(k), 32'h1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    function automatic logic pick(input int s);
        return (s == 0) ? irq_a : irq_b;
    endfunction
    // edges from one match pulse to the next
    task automatic period(input int s, output int p);
        int k;
        k = 0;
        while (pick(s) !== 1'b1 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        k = 0;
        @(posedge clk);
        while (pick(s) !== 1'b1 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        p = k + 1;
    endtask
    task automatic end_of_test;
        $display("error_cnt=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
    // =====================================================
    initial begin
        {resetn, cyc, stb, we} = 4'h0;
        {adr, wdat, sel} = 44'h3;
        {error_cnt, compares, ncap} = '0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            wb(rows[i].we, rows[i].adr, rows[i].dat);
            if (!rows[i].we) chk(q, rows[i].dat);
        end
        // interval timer on a, free compare on b within it
        wb(1'b1, 8'h10, 32'h5);
        wb(1'b1, 8'h14, 32'h3);
        wb(1'b1, 8'h08, 32'h4);
        wb(1'b1, 8'h00, 32'h8);
        period(0, n);
        chk(32'(n), 32'd24);
        period(1, n);
        chk(32'(n), 32'd24);
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b0, 8'h1C, 32'h0);
        chk(q, 32'h0);
        // b as capture register, every edge mode
        wb(1'b1, 8'h08, 32'h1);
        wb(1'b1, 8'h00, 32'h8);
        foreach (modes[i]) begin
            wb(1'b1, 8'h0C, {30'h0, modes[i][3:2]});
            ncap = 0;
            src_u.pulse(20, 20);
            chk(32'(ncap), {30'h0, modes[i][1:0]});
        end
        ncap = 0;
        src_u.pulse(2, 20);
        chk(32'(ncap), 32'h0);
        // width of a 40-clock high level is 10 ticks exactly
        wb(1'b1, 8'h0C, 32'h3);
        fork
            src_u.pulse(40, 20);
            begin
                repeat (20) @(posedge clk);
                wb(1'b0, 8'h18, 32'h0);
                v = q;
            end
        join
        wb(1'b0, 8'h18, 32'h0);
        chk((q - v) & 32'hFF, 32'h0A);
        v = q;
        repeat (30) @(posedge clk);
        wb(1'b0, 8'h14, 32'h0);
        chk(q, v);
        // clear on capture keeps the count small afterwards
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b1, 8'h08, 32'h9);
        wb(1'b1, 8'h00, 32'h8);
        repeat (200) @(posedge clk);
        src_u.pulse(20, 20);
        wb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, q < 32'h10}, 32'h1);
        // event mode: one edge and no edge both read zero, the flag tells them apart
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b1, 8'h08, 32'h0);
        wb(1'b1, 8'h04, 32'hF);
        wb(1'b1, 8'h0C, 32'h1);
        wb(1'b1, 8'h20, 32'h3);
        wb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 8'h00, 32'h8);
        src_u.pulse(20, 20);
        wb(1'b0, 8'h1C, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h2);
        src_u.pulse(20, 20);
        wb(1'b0, 8'h1C, 32'h0);
        chk(q, 32'h1);
        // width select: full word in 16-bit mode, low byte in 8-bit mode
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b1, 8'h04, 32'h0);
        wb(1'b1, 8'h10, 32'h1234);
        wb(1'b0, 8'h10, 32'h0);
        chk(q, 32'h1234);
        wb(1'b1, 8'h00, 32'h8);
        wb(1'b0, 8'h10, 32'h0);
        chk(q, 32'h34);
        // 1100 clocks, 275 ticks of 4 clocks, run the 8-bit count past its top
        wb(1'b1, 8'h20, 32'h3);
        repeat (1100) @(posedge clk);
        wb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h1);
        end_of_test();
    end
endmodule // tccu_top_test
`default_nettype wire
